// *** logic/imc_mode_slice.sv ***
`timescale 1ns/1ps
`include "imc_defs.svh"

module imc_mode_slice
    import imc_pkg::*;
#(
    parameter int ADDR_W   = 8,
    parameter int CHANNELS = 8
)
(
    input  wire logic                    i_clk,
    input  wire logic                    i_nrst,
    input  wire logic [ADDR_W-1:0]       i_avs_address,
    input  wire logic                    i_avs_read,
    input  wire logic                    i_avs_write,
    input  wire logic [31:0]             i_avs_writedata,
    input  wire logic [3:0]              i_avs_byteenable,
    output logic [31:0]                  o_avs_readdata,
    output logic                         o_avs_waitrequest,
    input  wire logic                    i_compare_event_7,
    input  wire logic                    i_dma_done_event_0,
    input  wire logic                    i_dma_done_event_1,
    output logic [`IMC_NUM_SLOTS-1:0]    o_cpu_req,
    output logic [3*`IMC_NUM_SLOTS-1:0]  o_cpu_level,
    output logic [CHANNELS-1:0]          o_dma_trig
);

    imc_bus_e                   bus_state_reg;
    imc_bus_e                   bus_state_next;
    logic [31:0]                rdata_reg;
    logic [31:0]                rdata_next;
    logic [`IMC_FIELD_W-1:0]    field_reg [`IMC_NUM_SLOTS];
    logic [`IMC_FIELD_W-1:0]    field_next [`IMC_NUM_SLOTS];
    logic [`IMC_NUM_SLOTS-1:0]  stat_reg;
    logic [`IMC_NUM_SLOTS-1:0]  stat_next;
    logic [`IMC_NUM_SLOTS-1:0]  slot_src;
    logic [`IMC_NUM_SLOTS-1:0]  slot_event;
    logic [CHANNELS-1:0]        slot_dma [`IMC_NUM_SLOTS];
    logic                       req_any;
    logic                       bus_ack;
    logic                       hit_mode;
    logic                       hit_stat;
    logic [31:0]                mode_word;

    // Packs the stored fields back into the slot layout; bits 7..6 read zero
    function automatic logic [31:0] pack_mode(input logic [`IMC_FIELD_W-1:0] f [`IMC_NUM_SLOTS]);
        pack_mode = `IMC_DATA_ZERO;
        for (int s = 0; s < `IMC_NUM_SLOTS; s++)
        begin
            pack_mode[s*`IMC_SLOT_W +: `IMC_FIELD_W] = f[s];
        end
    endfunction

    function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
        addr_is = (a == ADDR_W'(ofs));
    endfunction

    // Field pickers; the slot instances and the checks share one decode
    function automatic imc_sense_t slot_sense(input logic [`IMC_FIELD_W-1:0] f);
        slot_sense = f[`IMC_SENSE_MSB:`IMC_SENSE_LSB];
    endfunction

    function automatic logic slot_route(input logic [`IMC_FIELD_W-1:0] f);
        slot_route = f[`IMC_ROUTE_BIT];
    endfunction

    function automatic imc_level_t slot_level(input logic [`IMC_FIELD_W-1:0] f);
        slot_level = f[`IMC_LVL_MSB:`IMC_LVL_LSB];
    endfunction

    assign req_any  = i_avs_read | i_avs_write;
    assign bus_ack  = (bus_state_reg == IMC_BUS_ACK);
    assign hit_mode = addr_is(i_avs_address, `IMC_OFS_MODE);
    assign hit_stat = addr_is(i_avs_address, `IMC_OFS_STAT);
    // Packed view, so the checks can look back at a plain vector
    assign mode_word = pack_mode(field_reg);

    // One wait cycle: the read word is registered before it is offered
    assign o_avs_waitrequest = req_any & ~bus_ack;
    assign o_avs_readdata    = rdata_reg;

    always_comb
    begin
        bus_state_next = bus_state_reg;
        rdata_next     = rdata_reg;
        case (bus_state_reg)
            IMC_BUS_IDLE:
            begin
                if (req_any)
                begin
                    bus_state_next = IMC_BUS_ACK;
                    // Unmapped reads answer zero rather than stall
                    if (i_avs_read && hit_mode)
                    begin
                        rdata_next = pack_mode(field_reg);
                    end
                    else if (i_avs_read && hit_stat)
                    begin
                        rdata_next = {{(32-`IMC_NUM_SLOTS){1'b0}}, stat_reg};
                    end
                    else
                    begin
                        rdata_next = `IMC_DATA_ZERO;
                    end
                end
            end
            IMC_BUS_ACK:
            begin
                bus_state_next = IMC_BUS_IDLE;
            end
            default:
            begin
                bus_state_next = IMC_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            bus_state_reg <= IMC_BUS_IDLE;
            rdata_reg     <= `IMC_DATA_ZERO;
        end
        else
        begin
            bus_state_reg <= bus_state_next;
            rdata_reg     <= rdata_next;
        end
    end

    // Writes land on the acknowledge edge; each byte lane is one slot
    always_comb
    begin
        for (int s = 0; s < `IMC_NUM_SLOTS; s++)
        begin
            field_next[s] = field_reg[s];
            if (bus_ack && i_avs_write && hit_mode && i_avs_byteenable[s])
            begin
                field_next[s] = i_avs_writedata[s*`IMC_SLOT_W +: `IMC_FIELD_W];
            end
        end
        stat_next = stat_reg;
        if (bus_ack && i_avs_write && hit_stat)
        begin
            stat_next = stat_reg & ~i_avs_writedata[`IMC_NUM_SLOTS-1:0];
        end
        // A fresh edge in the clearing cycle is kept
        stat_next = stat_next | slot_event;
    end

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            for (int s = 0; s < `IMC_NUM_SLOTS; s++)
            begin
                field_reg[s] <= `IMC_FIELD_RST;
            end
            stat_reg <= `IMC_STAT_RST;
        end
        else
        begin
            for (int s = 0; s < `IMC_NUM_SLOTS; s++)
            begin
                field_reg[s] <= field_next[s];
            end
            stat_reg <= stat_next;
        end
    end

    // Slot 53 has no source behind it, so its fields stay inert
    assign slot_src[`IMC_SLOT_SRC52] = i_compare_event_7;
    assign slot_src[`IMC_SLOT_SRC53] = 1'b0;
    assign slot_src[`IMC_SLOT_SRC54] = i_dma_done_event_0;
    assign slot_src[`IMC_SLOT_SRC55] = i_dma_done_event_1;

    for (genvar g = 0; g < `IMC_NUM_SLOTS; g++)
    begin : g_slot
        imc_slot #(
            .CHANNELS (CHANNELS)
        ) u_slot (
            .i_clk       (i_clk),
            .i_nrst      (i_nrst),
            .i_src       (slot_src[g]),
            .i_sense     (slot_sense(field_reg[g])),
            .i_dma_route (slot_route(field_reg[g])),
            .i_level     (slot_level(field_reg[g])),
            .o_event     (slot_event[g]),
            .o_cpu_req   (o_cpu_req[g]),
            .o_cpu_level (o_cpu_level[3*g +: 3]),
            .o_dma_trig  (slot_dma[g])
        );
    end

    // Several slots may pick one channel; their triggers merge
    always_comb
    begin
        o_dma_trig = '0;
        for (int s = 0; s < `IMC_NUM_SLOTS; s++)
        begin
            o_dma_trig = o_dma_trig | slot_dma[s];
        end
    end

    sequence s_bus_req_idle;
        req_any && !bus_ack;
    endsequence

    sequence s_write_ack;
        bus_ack && i_avs_write;
    endsequence

    // Falling edge of the first DMA-completion source, routed to the processor
    sequence s_src54_fall_cpu;
        $past(i_nrst) && $past(i_dma_done_event_0) && !i_dma_done_event_0
            && slot_sense(field_reg[`IMC_SLOT_SRC54]) == `IMC_SENSE_FALL
            && !slot_route(field_reg[`IMC_SLOT_SRC54])
            && slot_level(field_reg[`IMC_SLOT_SRC54]) != `IMC_LVL_OFF;
    endsequence

    // Rising edge of the second DMA-completion source, routed to a channel
    sequence s_src55_rise_dma;
        $past(i_nrst) && !$past(i_dma_done_event_1) && i_dma_done_event_1
            && slot_sense(field_reg[`IMC_SLOT_SRC55]) == `IMC_SENSE_RISE
            && slot_route(field_reg[`IMC_SLOT_SRC55]);
    endsequence

    // Rising edge of the comparator source while its level reads zero
    sequence s_src52_rise_off;
        $past(i_nrst) && !$past(i_compare_event_7) && i_compare_event_7
            && slot_sense(field_reg[`IMC_SLOT_SRC52]) == `IMC_SENSE_RISE
            && !slot_route(field_reg[`IMC_SLOT_SRC52])
            && slot_level(field_reg[`IMC_SLOT_SRC52]) == `IMC_LVL_OFF;
    endsequence

    a_bus_one_wait: assert property (@(posedge i_clk) disable iff (!i_nrst)
        s_bus_req_idle |-> o_avs_waitrequest ##1 (bus_ack && !o_avs_waitrequest))
        else $error("request not answered after one wait cycle");

    a_bus_idle_free: assert property (@(posedge i_clk) disable iff (!i_nrst)
        !req_any |-> !o_avs_waitrequest)
        else $error("waitrequest raised with no request");

    a_mode_readback: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (req_any && !bus_ack && i_avs_read && hit_mode)
            |=> o_avs_readdata == $past(mode_word))
        else $error("mode register read mismatch");

    a_stat_readback: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (req_any && !bus_ack && i_avs_read && hit_stat)
            |=> o_avs_readdata[`IMC_NUM_SLOTS-1:0] == $past(stat_reg))
        else $error("status register read mismatch");

    a_unmapped_zero: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (req_any && !bus_ack && i_avs_read && !hit_mode && !hit_stat)
            |=> o_avs_readdata == `IMC_DATA_ZERO)
        else $error("unmapped read not zero");

    a_write_lane54: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (s_write_ack ##0 (hit_mode && i_avs_byteenable[`IMC_SLOT_SRC54]))
            |=> field_reg[`IMC_SLOT_SRC54]
                == $past(i_avs_writedata[`IMC_SLOT_SRC54*`IMC_SLOT_W +: `IMC_FIELD_W]))
        else $error("write to bits 23..16 did not land in slot 54");

    a_lane_kept: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (s_write_ack ##0 (hit_mode && !i_avs_byteenable[`IMC_SLOT_SRC55]))
            |=> field_reg[`IMC_SLOT_SRC55] == $past(field_reg[`IMC_SLOT_SRC55]))
        else $error("disabled byte lane changed slot 55");

    a_stat_clear: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (s_write_ack ##0 (hit_stat && slot_event == '0))
            |=> (stat_reg & $past(i_avs_writedata[`IMC_NUM_SLOTS-1:0])) == '0)
        else $error("status bit not cleared by write of one");

    a_src54_maps_slot: assert property (@(posedge i_clk) disable iff (!i_nrst)
        s_src54_fall_cpu
            |=> o_cpu_req[`IMC_SLOT_SRC54] && slot_dma[`IMC_SLOT_SRC54] == '0
                && o_cpu_level[3*`IMC_SLOT_SRC54 +: 3]
                    == $past(slot_level(field_reg[`IMC_SLOT_SRC54])))
        else $error("source 54 not delivered from bits 23..16");

    a_src55_dma_trig: assert property (@(posedge i_clk) disable iff (!i_nrst)
        s_src55_rise_dma
            |=> o_dma_trig[$past(slot_level(field_reg[`IMC_SLOT_SRC55]))]
                && !o_cpu_req[`IMC_SLOT_SRC55])
        else $error("source 55 trigger missing on its channel");

    a_src52_level_off: assert property (@(posedge i_clk) disable iff (!i_nrst)
        s_src52_rise_off
            |=> !o_cpu_req[`IMC_SLOT_SRC52] && slot_dma[`IMC_SLOT_SRC52] == '0
                && slot_event[`IMC_SLOT_SRC52])
        else $error("disabled source 52 still raised a request");

    a_unused_slot_quiet: assert property (@(posedge i_clk) disable iff (!i_nrst)
        !o_cpu_req[`IMC_SLOT_SRC53] && slot_dma[`IMC_SLOT_SRC53] == '0)
        else $error("unused slot raised an event");

    a_status_sticky: assert property (@(posedge i_clk) disable iff (!i_nrst)
        slot_event[`IMC_SLOT_SRC54] |=> stat_reg[`IMC_SLOT_SRC54])
        else $error("event lost from status");

endmodule

// *** common/imc_defs.svh ***
`ifndef IMC_DEFS_SVH
`define IMC_DEFS_SVH

// Register byte offsets within the slave window
`define IMC_OFS_MODE     8'h34
`define IMC_OFS_STAT     8'h40

// One 8-bit slot per source inside the mode register
`define IMC_SLOT_W       8
`define IMC_NUM_SLOTS    4
`define IMC_FIELD_W      6
`define IMC_LVL_LSB      0
`define IMC_LVL_MSB      2
`define IMC_ROUTE_BIT    3
`define IMC_SENSE_LSB    4
`define IMC_SENSE_MSB    5

// Slot index of each source: 52 at bits 7..0 up to 55 at bits 31..24
`define IMC_SLOT_SRC52   0
`define IMC_SLOT_SRC53   1
`define IMC_SLOT_SRC54   2
`define IMC_SLOT_SRC55   3

// Sensitivity codes; 00 and 01 detect nothing here
`define IMC_SENSE_FALL   2'h2
`define IMC_SENSE_RISE   2'h3

`define IMC_LVL_OFF      3'h0
`define IMC_FIELD_RST    6'h00
`define IMC_STAT_RST     4'h0
`define IMC_DATA_ZERO    32'h0000_0000

`endif

// *** common/imc_pkg.sv ***
package imc_pkg;

    typedef enum logic [1:0] {
        IMC_BUS_IDLE = 2'b01,
        IMC_BUS_ACK  = 2'b10
    } imc_bus_e;

    typedef logic [2:0] imc_level_t;
    typedef logic [1:0] imc_sense_t;

endpackage

// *** logic/imc_slot.sv ***
`timescale 1ns/1ps
`include "imc_defs.svh"

module imc_slot
    import imc_pkg::*;
#(
    parameter int CHANNELS = 8
)
(
    input  wire logic                i_clk,
    input  wire logic                i_nrst,
    input  wire logic                i_src,
    input  wire imc_pkg::imc_sense_t i_sense,
    input  wire logic                i_dma_route,
    input  wire imc_pkg::imc_level_t i_level,
    output logic                     o_event,
    output logic                     o_cpu_req,
    output imc_pkg::imc_level_t      o_cpu_level,
    output logic [CHANNELS-1:0]      o_dma_trig
);

    logic                src_d_reg;
    logic                src_d_next;
    logic                event_reg;
    logic                event_next;
    logic                cpu_req_reg;
    logic                cpu_req_next;
    imc_level_t          level_reg;
    imc_level_t          level_next;
    logic [CHANNELS-1:0] dma_reg;
    logic [CHANNELS-1:0] dma_next;
    logic                edge_hit;

    function automatic logic detect(input imc_sense_t sense, input logic now, input logic was);
        case (sense)
            `IMC_SENSE_FALL: detect = was & ~now;
            `IMC_SENSE_RISE: detect = now & ~was;
            default:         detect = 1'b0;
        endcase
    endfunction

    assign edge_hit = detect(i_sense, i_src, src_d_reg);

    always_comb
    begin
        src_d_next   = i_src;
        event_next   = edge_hit;
        level_next   = i_level;
        // Level 000 switches the processor request off
        cpu_req_next = edge_hit & ~i_dma_route & (i_level != `IMC_LVL_OFF);
        dma_next     = '0;
        if (edge_hit && i_dma_route)
        begin
            dma_next[i_level] = 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            src_d_reg   <= 1'b0;
            event_reg   <= 1'b0;
            cpu_req_reg <= 1'b0;
            level_reg   <= `IMC_LVL_OFF;
            dma_reg     <= '0;
        end
        else
        begin
            src_d_reg   <= src_d_next;
            event_reg   <= event_next;
            cpu_req_reg <= cpu_req_next;
            level_reg   <= level_next;
            dma_reg     <= dma_next;
        end
    end

    assign o_event     = event_reg;
    assign o_cpu_req   = cpu_req_reg;
    assign o_cpu_level = level_reg;
    assign o_dma_trig  = dma_reg;

    sequence s_dma_edge;
        edge_hit && i_dma_route;
    endsequence

    a_level_zero_off: assert property (@(posedge i_clk) disable iff (!i_nrst)
        o_cpu_req |-> (o_cpu_level != `IMC_LVL_OFF))
        else $error("processor request raised with level zero");

    a_dma_channel_hit: assert property (@(posedge i_clk) disable iff (!i_nrst)
        s_dma_edge |=> (o_dma_trig == (CHANNELS'(1) << $past(i_level))) && !o_cpu_req)
        else $error("dma trigger not on selected channel");

    a_cpu_route_only: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (edge_hit && !i_dma_route && i_level != `IMC_LVL_OFF)
            |=> o_cpu_req && o_dma_trig == '0 && o_cpu_level == $past(i_level))
        else $error("processor route did not raise request");

endmodule

// *** testbench/imc_far_model.sv ***
`timescale 1ns/1ps

module imc_far_model
(
    input  wire logic        i_clk,
    input  wire logic        i_nrst,
    input  wire logic        i_clr,
    input  wire logic [3:0]  i_cpu_req,
    input  wire logic [11:0] i_cpu_level,
    input  wire logic [7:0]  i_dma_trig,
    output logic      [3:0]  o_req_seen,
    output logic      [11:0] o_level_seen,
    output logic      [7:0]  o_trig_seen
);
    // Sticky, so a one-cycle pulse survives until the bench looks
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            {o_req_seen, o_level_seen, o_trig_seen} <= '0;
        else if (i_clr)
            {o_req_seen, o_level_seen, o_trig_seen} <= '0;
        else
        begin
            o_req_seen  <= o_req_seen | i_cpu_req;
            o_trig_seen <= o_trig_seen | i_dma_trig;
            for (int n = 0; n < 4; n++)
                if (i_cpu_req[n])
                    o_level_seen[3*n +: 3] <= i_cpu_level[3*n +: 3];
        end
    end
endmodule

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
`include "imc_defs.svh"

module tb_top;
    import imc_pkg::*;
    logic        clk;
    logic        nrst;
    logic        av_rd;
    logic        av_wr;
    logic [7:0]  av_addr;
    logic [31:0] av_wdata;
    logic [3:0]  av_be;
    logic [31:0] av_rdata;
    logic        av_wait;
    logic [3:0]  src;
    logic [3:0]  cpu_req;
    logic [11:0] cpu_lvl;
    logic [7:0]  dma_trig;
    logic        clr;
    logic [3:0]  req_seen;
    logic [11:0] lvl_seen;
    logic [7:0]  trig_seen;
    int          error_cnt;
    int          n_checks;

    imc_mode_slice #(.ADDR_W(8), .CHANNELS(8)) u_dut
    (
        .i_clk(clk), .i_nrst(nrst), .i_avs_address(av_addr),
        .i_avs_read(av_rd), .i_avs_write(av_wr), .i_avs_writedata(av_wdata),
        .i_avs_byteenable(av_be), .o_avs_readdata(av_rdata),
        .o_avs_waitrequest(av_wait), .i_compare_event_7(src[0]),
        .i_dma_done_event_0(src[2]), .i_dma_done_event_1(src[3]),
        .o_cpu_req(cpu_req), .o_cpu_level(cpu_lvl), .o_dma_trig(dma_trig)
    );

    imc_far_model u_far
    (
        .i_clk(clk), .i_nrst(nrst), .i_clr(clr), .i_cpu_req(cpu_req),
        .i_cpu_level(cpu_lvl), .i_dma_trig(dma_trig), .o_req_seen(req_seen),
        .o_level_seen(lvl_seen), .o_trig_seen(trig_seen)
    );

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic results;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Waitrequest is judged at each rising edge; the edge that sees it low takes the data
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] b, output logic [31:0] q);
        @(posedge clk);
        av_wr <= w;
        av_rd <= !w;
        av_addr <= a;
        av_wdata <= d;
        av_be <= b;
        @(posedge clk);
        while (av_wait)
            @(posedge clk);
        q = av_rdata;
        av_wr <= 1'b0;
        av_rd <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
        logic [31:0] q;
        bus(1'b1, a, d, b, q);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, 4'hF, q);
        chk(nm, q, e);
    endtask

    // One rising and one falling edge per call; the sense field picks one
    task automatic run(input logic [31:0] m, input int s, input logic [3:0] ce,
                       input logic [11:0] le, input logic [7:0] te);
        wr(`IMC_OFS_MODE, m, 4'hF);
        @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        src[s] <= 1'b1;
        repeat (3) @(posedge clk);
        src[s] <= 1'b0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk("cpu_req", {28'h0, req_seen}, {28'h0, ce});
        chk("cpu_level", {20'h0, lvl_seen}, {20'h0, le});
        chk("dma_trig", {24'h0, trig_seen}, {24'h0, te});
    endtask

    initial
    begin
        nrst = 1'b0;
        av_rd = 1'b0;
        av_wr = 1'b0;
        av_addr = 8'h00;
        av_wdata = 32'h0;
        av_be = 4'hF;
        src = 4'h0;
        clr = 1'b0;
        error_cnt = 0;
        n_checks = 0;
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        rd(`IMC_OFS_MODE, 32'h0, "mode_reset");
        wr(8'h38, 32'hFFFF_FFFF, 4'hF);
        rd(8'h38, 32'h0, "unmapped");
        rd(`IMC_OFS_MODE, 32'h0, "mode_untouched");
        wr(`IMC_OFS_MODE, 32'hFD23_0037, 4'hF);
        rd(`IMC_OFS_MODE, 32'h3D23_0037, "mode_readback");
        wr(`IMC_OFS_MODE, 32'h2A2A_2A30, 4'h1);
        rd(`IMC_OFS_MODE, 32'h3D23_0030, "mode_lane");
        // Every full write keeps source 54 on falling, live slots on 10 or 11, slot 53 zero
        run(32'h3023_0030, 2, 4'h4, 12'h0C0, 8'h00);
        run(32'h3D20_0030, 3, 4'h0, 12'h000, 8'h20);
        run(32'h3020_0030, 0, 4'h0, 12'h000, 8'h00);
        run(32'h3020_0037, 0, 4'h1, 12'h007, 8'h00);
        for (int c = 0; c < 8; c++)
            run(32'h3028_0030 | (32'(c) << 16), 2, 4'h0, 12'h000, 8'h01 << c);
        rd(`IMC_OFS_STAT, 32'h0000_000D, "status");
        wr(`IMC_OFS_STAT, 32'h0000_000F, 4'hF);
        rd(`IMC_OFS_STAT, 32'h0, "status_clear");
        results();
    end

    // The whole sequence takes under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        results();
    end
endmodule
